// File: design/ddaopr_regs.svh
`ifndef DDAOPR_REGS_SVH
`define DDAOPR_REGS_SVH

// register addresses on the serial programming interface
`define DDAOPR_ADDR_W          7
`define DDAOPR_ADDR_ALERT      7'h07
`define DDAOPR_ADDR_OFFS_A     7'h08
`define DDAOPR_ADDR_START_B    7'h09
`define DDAOPR_ADDR_SCALE_PWR  7'h0A

// reset values
`define DDAOPR_RST_ALERT       16'hFFFF
`define DDAOPR_RST_OFFS_A      16'h4000
`define DDAOPR_RST_START_B     16'h8000
`define DDAOPR_RST_SCALE_PWR   16'hF080

// writable bits; the rest always show their reset value
`define DDAOPR_WMASK_ALERT     16'hFFFF
`define DDAOPR_WMASK_OFFS_A    16'h1FFF
`define DDAOPR_WMASK_START_B   16'hFFFF
`define DDAOPR_WMASK_SCALE_PWR 16'hF9E0

// field positions
`define DDAOPR_OFFS_MSB        12
`define DDAOPR_START_MSB       15
`define DDAOPR_START_LSB       13
`define DDAOPR_COARSE_MSB      15
`define DDAOPR_COARSE_LSB      12
`define DDAOPR_FUSE_SLEEP_BIT  11
`define DDAOPR_TSENSE_BIT      8
`define DDAOPR_CLKRECV_BIT     7
`define DDAOPR_SLEEP_A_BIT     6
`define DDAOPR_SLEEP_B_BIT     5
`define DDAOPR_MUTE_MASK_BIT   5

// alarm bits that reach the alert pin (bit 5 does not)
`define DDAOPR_PIN_ALARMS      16'hFFDF
`define DDAOPR_MID_CODE        16'h8000

// serial frame: read flag and address, then one data word
`define DDAOPR_INSTR_BITS      8
`define DDAOPR_FRAME_BITS      24
`define DDAOPR_READ_BIT        7

`endif

// File: design/ddaopr_pkg.sv
package ddaopr_pkg;

    typedef enum logic [1:0] {
        DDAOPR_PH_INSTR,
        DDAOPR_PH_DATA,
        DDAOPR_PH_DONE
    } ddaopr_phase_e;

    typedef logic [15:0] ddaopr_word_t;

endpackage

// File: design/ddaopr_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddaopr_regs.svh"

module ddaopr_serial_port
    import ddaopr_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire logic                      sclk,
    input  wire logic                      sdenb_n,
    input  wire logic                      sdio_in,
    output logic                           sdio_out,
    output logic                           sdio_oe,
    output logic [`DDAOPR_ADDR_W-1:0]      addr,
    output logic                           wr_stb,
    output ddaopr_word_t                   wdata,
    input  wire ddaopr_word_t              rdata
);

    ddaopr_phase_e        phase, next_phase;
    logic [4:0]           cnt, next_cnt;
    logic [7:0]           instr, next_instr;
    ddaopr_word_t         next_wdata, tx, next_tx;
    logic                 sclk_q, rise, fall;
    logic                 load_pend, next_load_pend;
    logic                 next_wr_stb, next_out, next_oe;
    logic [`DDAOPR_ADDR_W-1:0] next_addr;

    // sclk is sampled by clk; each half period must span at least two clk cycles
    assign rise = sclk & ~sclk_q;
    assign fall = ~sclk & sclk_q;

    always_comb begin
        next_phase     = phase;
        next_cnt       = cnt;
        next_instr     = instr;
        next_wdata     = wdata;
        next_tx        = tx;
        next_addr      = addr;
        next_load_pend = 1'b0;
        next_wr_stb    = 1'b0;
        next_out       = sdio_out;
        next_oe        = sdio_oe;
        if (sdenb_n) begin
            // frame aborted or finished: restart and release the pin
            next_phase = DDAOPR_PH_INSTR;
            next_cnt   = 5'h00;
            next_oe    = 1'b0;
        end else begin
            // addr is registered one cycle after the last address bit and rdata decodes it combinationally, so capture it here
            if (load_pend) begin
                next_tx = rdata;
            end
            unique case (phase)
                DDAOPR_PH_INSTR: begin
                    if (rise) begin
                        next_instr = {instr[6:0], sdio_in};
                        next_cnt   = cnt + 5'h01;
                        if (cnt == 5'(`DDAOPR_INSTR_BITS - 1)) begin
                            next_addr      = {instr[5:0], sdio_in};
                            next_load_pend = instr[`DDAOPR_READ_BIT - 1];
                            next_phase     = DDAOPR_PH_DATA;
                        end
                    end
                end
                DDAOPR_PH_DATA: begin
                    if (fall && instr[`DDAOPR_READ_BIT]) begin
                        next_out = tx[15];
                        next_tx  = {tx[14:0], 1'b0};
                        next_oe  = 1'b1;
                    end
                    if (rise) begin
                        next_wdata = {wdata[14:0], sdio_in};
                        next_cnt   = cnt + 5'h01;
                        if (cnt == 5'(`DDAOPR_FRAME_BITS - 1)) begin
                            next_wr_stb = ~instr[`DDAOPR_READ_BIT];
                            next_phase  = DDAOPR_PH_DONE;
                        end
                    end
                end
                DDAOPR_PH_DONE: begin
                    // extra clocks in a frame are ignored
                    next_phase = DDAOPR_PH_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            phase     <= DDAOPR_PH_INSTR;
            cnt       <= 5'h00;
            instr     <= 8'h00;
            wdata     <= 16'h0000;
            tx        <= 16'h0000;
            addr      <= 7'h00;
            load_pend <= 1'b0;
            wr_stb    <= 1'b0;
            sdio_out  <= 1'b0;
            sdio_oe   <= 1'b0;
            sclk_q    <= 1'b0;
        end else begin
            phase     <= next_phase;
            cnt       <= next_cnt;
            instr     <= next_instr;
            wdata     <= next_wdata;
            tx        <= next_tx;
            addr      <= next_addr;
            load_pend <= next_load_pend;
            wr_stb    <= next_wr_stb;
            sdio_out  <= next_out;
            sdio_oe   <= next_oe;
            sclk_q    <= sclk;
        end
    end

endmodule
`default_nettype wire

// File: design/ddaopr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddaopr_regs.svh"

module ddaopr_top
    import ddaopr_pkg::*;
#(
    parameter int WORD_W = 16
) (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               sclk,
    input  wire logic               sdenb_n,
    input  wire logic               sdio_in,
    output logic                    sdio_out,
    output logic                    sdio_oe,
    input  wire logic [15:0]        alarm_src,
    input  wire logic               clock_gone,
    input  wire logic               conv_sync,
    input  wire logic [WORD_W-1:0]  word_a_in,
    input  wire logic [WORD_W-1:0]  word_b_in,
    output logic [15:0]             alarm_mask,
    output logic                    alert,
    output logic                    output_mute,
    output logic [12:0]             offset_a,
    output logic [12:0]             offset_b,
    output logic                    offset_sync,
    output logic [2:0]              read_start,
    output logic [2:0]              read_index,
    output logic [3:0]              coarse_current,
    output logic [4:0]              full_scale_steps,
    output logic                    fuse_sleep,
    output logic                    tsense_sleep,
    output logic                    clkrecv_ena,
    output logic                    sleep_a,
    output logic                    sleep_b,
    output logic [WORD_W-1:0]       word_a_out,
    output logic [WORD_W-1:0]       word_b_out
);

    // the mid-code word is sixteen bits wide
    if (WORD_W != 16) begin : g_bad_width
        $error("ddaopr_top: WORD_W must be 16");
    end

    logic [`DDAOPR_ADDR_W-1:0] addr;
    logic                      wr_stb;
    ddaopr_word_t              wdata, rdata;

    ddaopr_word_t reg_alert, reg_offs_a, reg_start_b, reg_scale;
    ddaopr_word_t next_alert, next_offs_a, next_start_b, next_scale;
    logic         next_sync;
    logic [2:0]   next_index;
    logic [15:0]  live_alarm;
    logic         next_alert_pin, next_mute;
    logic [WORD_W-1:0] next_word_a, next_word_b;
    logic [4:0]   next_steps;

    ddaopr_serial_port u_port (
        .clk      (clk),
        .srst     (srst),
        .sclk     (sclk),
        .sdenb_n  (sdenb_n),
        .sdio_in  (sdio_in),
        .sdio_out (sdio_out),
        .sdio_oe  (sdio_oe),
        .addr     (addr),
        .wr_stb   (wr_stb),
        .wdata    (wdata),
        .rdata    (rdata)
    );

    always_comb begin
        unique case (addr)
            `DDAOPR_ADDR_ALERT:     rdata = reg_alert;
            `DDAOPR_ADDR_OFFS_A:    rdata = reg_offs_a;
            `DDAOPR_ADDR_START_B:   rdata = reg_start_b;
            `DDAOPR_ADDR_SCALE_PWR: rdata = reg_scale;
            default:                rdata = 16'h0000;
        endcase
    end

    always_comb begin
        next_alert   = reg_alert;
        next_offs_a  = reg_offs_a;
        next_start_b = reg_start_b;
        next_scale   = reg_scale;
        next_sync    = 1'b0;
        if (wr_stb) begin
            unique case (addr)
                `DDAOPR_ADDR_ALERT: begin
                    next_alert = wdata & `DDAOPR_WMASK_ALERT;
                end
                `DDAOPR_ADDR_OFFS_A: begin
                    next_offs_a = (wdata & `DDAOPR_WMASK_OFFS_A)
                                | (`DDAOPR_RST_OFFS_A & ~`DDAOPR_WMASK_OFFS_A);
                end
                `DDAOPR_ADDR_START_B: begin
                    next_start_b = wdata & `DDAOPR_WMASK_START_B;
                    next_sync    = 1'b1;
                end
                `DDAOPR_ADDR_SCALE_PWR: begin
                    next_scale = (wdata & `DDAOPR_WMASK_SCALE_PWR)
                               | (`DDAOPR_RST_SCALE_PWR & ~`DDAOPR_WMASK_SCALE_PWR);
                end
                default: begin
                    next_sync = 1'b0;
                end
            endcase
        end
    end

    for (genvar i = 0; i < 16; i++) begin : g_alarm
        assign live_alarm[i] = alarm_src[i] & ~reg_alert[i];
    end

    always_comb begin
        // bit 5 kept off the pin
        next_alert_pin = |(live_alarm & `DDAOPR_PIN_ALARMS);
        next_mute = clock_gone & ~reg_alert[`DDAOPR_MUTE_MASK_BIT];
        next_word_a = next_mute ? `DDAOPR_MID_CODE : word_a_in;
        next_word_b = next_mute ? `DDAOPR_MID_CODE : word_b_in;
        next_index = conv_sync ? reg_start_b[`DDAOPR_START_MSB:`DDAOPR_START_LSB]
                               : read_index;
        next_steps = {1'b0, reg_scale[`DDAOPR_COARSE_MSB:`DDAOPR_COARSE_LSB]} + 5'h01;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_alert   <= `DDAOPR_RST_ALERT;
            reg_offs_a  <= `DDAOPR_RST_OFFS_A;
            reg_start_b <= `DDAOPR_RST_START_B;
            reg_scale   <= `DDAOPR_RST_SCALE_PWR;
            offset_sync <= 1'b0;
            read_index  <= 3'h4;
            alert       <= 1'b0;
            output_mute <= 1'b0;
            word_a_out  <= `DDAOPR_MID_CODE;
            word_b_out  <= `DDAOPR_MID_CODE;
            full_scale_steps <= 5'h10;
        end else begin
            reg_alert   <= next_alert;
            reg_offs_a  <= next_offs_a;
            reg_start_b <= next_start_b;
            reg_scale   <= next_scale;
            offset_sync <= next_sync;
            read_index  <= next_index;
            alert       <= next_alert_pin;
            output_mute <= next_mute;
            word_a_out  <= next_word_a;
            word_b_out  <= next_word_b;
            full_scale_steps <= next_steps;
        end
    end

    // field views of the register flops
    assign alarm_mask     = reg_alert;
    assign offset_a       = reg_offs_a[`DDAOPR_OFFS_MSB:0];
    assign offset_b       = reg_start_b[`DDAOPR_OFFS_MSB:0];
    assign read_start     = reg_start_b[`DDAOPR_START_MSB:`DDAOPR_START_LSB];
    assign coarse_current = reg_scale[`DDAOPR_COARSE_MSB:`DDAOPR_COARSE_LSB];
    assign fuse_sleep     = reg_scale[`DDAOPR_FUSE_SLEEP_BIT];
    assign tsense_sleep   = reg_scale[`DDAOPR_TSENSE_BIT];
    assign clkrecv_ena    = reg_scale[`DDAOPR_CLKRECV_BIT];
    assign sleep_a        = reg_scale[`DDAOPR_SLEEP_A_BIT];
    assign sleep_b        = reg_scale[`DDAOPR_SLEEP_B_BIT];

endmodule
`default_nettype wire

// File: test/ddaopr_host.sv
`timescale 1ns/1ps
`default_nettype none
module ddaopr_host (
    input  wire logic clk,
    input  wire logic sdio_out,
    output logic      sclk,
    output logic      sdenb_n,
    output logic      sdio_in
);
    int half = 2;
    initial begin
        sclk = 1'b0;
        sdenb_n = 1'b1;
        sdio_in = 1'b0;
    end
    // fewer than 24 bits makes an aborted frame
    task automatic frame(input logic [23:0] w, input int nbits, output logic [15:0] q);
        q = '0;
        @(negedge clk);
        sdenb_n = 1'b0;
        for (int i = 23; i > 23 - nbits; i--) begin
            // line left to the device during read data shows no stale bit
            sdio_in = (w[23] && i < 16) ? ~sdio_in : w[i];
            repeat (half) @(negedge clk);
            q = {q[14:0], sdio_out};
            sclk = 1'b1;
            repeat (half) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (half) @(negedge clk);
        sdenb_n = 1'b1;
        sdio_in = ~sdio_in;
        repeat (2) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// File: test/ddaopr_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ddaopr_top_assertions #(
    parameter int WORD_W = 16
) (
    input wire logic              clk,
    input wire logic              srst,
    input wire logic [15:0]       alarm_src,
    input wire logic              clock_gone,
    input wire logic              conv_sync,
    input wire logic [WORD_W-1:0] word_a_in,
    input wire logic [15:0]       alarm_mask,
    input wire logic              alert,
    input wire logic              output_mute,
    input wire logic [12:0]       offset_b,
    input wire logic              offset_sync,
    input wire logic [2:0]        read_start,
    input wire logic [2:0]        read_index,
    input wire logic [3:0]        coarse_current,
    input wire logic [4:0]        full_scale_steps,
    input wire logic              clkrecv_ena,
    input wire logic [WORD_W-1:0] word_a_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_alert;
        !$past(srst) |-> alert == |($past(alarm_src) & ~$past(alarm_mask) & 16'hFFDF);
    endproperty
    a_alert: assert property (p_alert) else $error("alert wrong");
    property p_mute;
        !$past(srst) |-> output_mute == ($past(clock_gone) && !$past(alarm_mask[5]));
    endproperty
    a_mute: assert property (p_mute) else $error("mute wrong");
    property p_word;
        !$past(srst) |-> word_a_out == (output_mute ? 16'h8000 : $past(word_a_in));
    endproperty
    a_word: assert property (p_word) else $error("word wrong");
    property p_sync_pulse;
        offset_sync |=> !offset_sync;
    endproperty
    a_sync_pulse: assert property (p_sync_pulse) else $error("sync too long");
    property p_sync_cause;
        !$past(srst) && ($changed(offset_b) || $changed(read_start)) |-> offset_sync;
    endproperty
    a_sync_cause: assert property (p_sync_cause) else $error("no sync");
    property p_index;
        !$past(srst) && $past(conv_sync) |-> read_index == $past(read_start);
    endproperty
    a_index: assert property (p_index) else $error("index not loaded");
    property p_index_hold;
        !$past(srst) && !$past(conv_sync) |-> $stable(read_index);
    endproperty
    a_index_hold: assert property (p_index_hold) else $error("index moved");
    property p_scale;
        !$past(srst) |-> full_scale_steps == $past(coarse_current) + 5'h01;
    endproperty
    a_scale: assert property (p_scale) else $error("steps wrong");
    property p_rst;
        $past(srst) |-> alarm_mask == 16'hFFFF && clkrecv_ena && coarse_current == 4'hF;
    endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");
    c_sync: cover property (offset_sync);
    c_mute: cover property (output_mute);
    c_load: cover property (conv_sync ##1 read_index != 3'h4);
endmodule
`default_nettype wire

// File: test/ddaopr_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ddaopr_tb;
    localparam logic [6:0]  ADR [5] = '{7'h07, 7'h08, 7'h09, 7'h0A, 7'h0B};
    localparam logic [15:0] RST [5] = '{16'hFFFF, 16'h4000, 16'h8000, 16'hF080, 16'h0000};
    localparam logic [15:0] WM [5]  = '{16'hFFFF, 16'h1FFF, 16'hFFFF, 16'hF9E0, 16'h0000};
    logic        clk, srst, clock_gone, conv_sync, sclk, sdenb_n, sdio_in, sdio_out, sdio_oe;
    logic        alert, output_mute, offset_sync, fuse_sleep, tsense_sleep, clkrecv_ena;
    logic        sleep_a, sleep_b, oe_seen;
    logic [15:0] alarm_src, alarm_mask, word_a_in, word_b_in, word_a_out, word_b_out, q, v;
    logic [15:0] sh [5];
    logic [12:0] offset_a, offset_b;
    logic [2:0]  read_start, read_index;
    logic [3:0]  coarse_current;
    logic [4:0]  full_scale_steps;
    int          fails = 0, compares = 0, cycles = 0, nsync = 0, n0, i;
    int          seed = 32'h7825f061;

    ddaopr_top #(.WORD_W(16)) dut (.clk, .srst, .sclk, .sdenb_n, .sdio_in, .sdio_out, .sdio_oe,
        .alarm_src, .clock_gone, .conv_sync, .word_a_in, .word_b_in, .alarm_mask, .alert,
        .output_mute, .offset_a, .offset_b, .offset_sync, .read_start, .read_index,
        .coarse_current, .full_scale_steps, .fuse_sleep, .tsense_sleep, .clkrecv_ena, .sleep_a,
        .sleep_b, .word_a_out, .word_b_out);
    ddaopr_host host (.clk, .sdio_out, .sclk, .sdenb_n, .sdio_in);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // look at settled outputs, away from the edge that launches them
    always @(negedge clk) begin
        cycles++;
        if (offset_sync)
            nsync++;
        if (sdio_oe)
            oe_seen = 1'b1;
        if (cycles == 30000) begin
            fails++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic exp_alert(input logic [15:0] src, input logic [15:0] msk);
        return |(src & ~msk & 16'hFFDF);
    endfunction
    task automatic wr(input int k, input logic [15:0] d);
        oe_seen = 1'b0;
        host.frame({1'b0, ADR[k], d}, 24, q);
        sh[k] = (d & WM[k]) | (sh[k] & ~WM[k]);
        check("oe_write", {15'h0, oe_seen}, 16'h0000);
    endtask
    task automatic rd(input int k);
        oe_seen = 1'b0;
        host.frame({1'b1, ADR[k], 16'h0000}, 24, q);
        check("readback", q, sh[k]);
        check("oe_read", {14'h0, oe_seen, sdio_oe}, 16'h0002);
    endtask
    task automatic fields();
        check("mask", alarm_mask, sh[0]);
        check("offs_a", {3'h0, offset_a}, {3'h0, sh[1][12:0]});
        check("offs_b", {3'h0, offset_b}, {3'h0, sh[2][12:0]});
        check("start", {13'h0, read_start}, {13'h0, sh[2][15:13]});
        check("coarse", {12'h0, coarse_current}, {12'h0, sh[3][15:12]});
        check("steps", {11'h0, full_scale_steps}, {12'h0, sh[3][15:12]} + 16'h1);
        check("pwr", {11'h0, fuse_sleep, tsense_sleep, clkrecv_ena, sleep_a, sleep_b},
              {11'h0, sh[3][11], sh[3][8:5]});
    endtask

    initial begin
        srst = 1'b1;
        {alarm_src, clock_gone, conv_sync, word_a_in, word_b_in} = '0;
        sh = RST;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        fields();
        for (int k = 0; k < 5; k++)
            rd(k);
        for (int k = 0; k < 24; k++) begin
            host.half = (k % 4 == 3) ? 5 : 2;
            i = (k < 5) ? k : (($random(seed) & 32'h7FFFFFFF) % 5);
            v = (k < 5) ? 16'h0000 : $random(seed);
            n0 = nsync;
            wr(i, v);
            check("syncs", 16'(nsync - n0), {15'h0, i == 2});
            fields();
            rd(i);
            conv_sync = 1'b1;
            @(negedge clk);
            conv_sync = 1'b0;
            check("index", {13'h0, read_index}, {13'h0, sh[2][15:13]});
        end
        wr(3, 16'h00A0);
        fields();
        host.frame({1'b0, ADR[0], 16'h1234}, 20, q);
        rd(0);
        for (int k = 0; k < 12; k++) begin
            wr(0, (k < 2) ? 16'hFFDF : $random(seed));
            alarm_src = (k < 2) ? 16'h0020 : $random(seed);
            clock_gone = k[0];
            word_a_in = $random(seed);
            word_b_in = $random(seed);
            @(negedge clk);
            check("alert", {15'h0, alert}, {15'h0, exp_alert(alarm_src, sh[0])});
            check("mute", {15'h0, output_mute}, {15'h0, clock_gone & ~sh[0][5]});
            check("word_a", word_a_out, (clock_gone & ~sh[0][5]) ? 16'h8000 : word_a_in);
            check("word_b", word_b_out, (clock_gone & ~sh[0][5]) ? 16'h8000 : word_b_in);
        end
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        sh = RST;
        fields();
        check("index_rst", {13'h0, read_index}, 16'h0004);
        rd(3);
        test_done();
    end
endmodule

bind ddaopr_top ddaopr_top_assertions #(.WORD_W(WORD_W)) chk (.clk, .srst, .alarm_src,
    .clock_gone, .conv_sync, .word_a_in, .alarm_mask, .alert, .output_mute, .offset_b,
    .offset_sync, .read_start, .read_index, .coarse_current, .full_scale_steps,
    .clkrecv_ena, .word_a_out);
`default_nettype wire
